// [logic/bank_map.svh]
// offsets, field positions, reset values and command codes
`ifndef BANK_MAP_SVH
`define BANK_MAP_SVH
`define COMMON_SIZE      32
`define BANK_SIZE        32
`define BANK_DEPTH       96
`define BANK_BASE        6'h20
`define ADDR_RADIO_CFG   5'h00
`define ADDR_RESET_CLK   5'h01
`define ADDR_IRQ_CFG     5'h02
`define ADDR_IRQ_MASK    5'h03
`define ADDR_IRQ_FLAGS   5'h04
`define ADDR_RSVD_LOW    5'h05
`define ADDR_GPIO_LOW    5'h06
`define ADDR_GPIO_HIGH   5'h07
`define ADDR_PAD_PULLUP  5'h08
`define ADDR_TX_FIFO_SA  5'h09
`define ADDR_FIFO_MODE   5'h0a
`define ADDR_TX_PREAMB   5'h0b
`define ADDR_PKT_FORMAT  5'h0c
`define ADDR_PKT_CODING  5'h0d
`define ADDR_WHITENING   5'h0e
`define ADDR_TX_PAYLOAD  5'h0f
`define ADDR_RX_PAYLOAD  5'h10
`define ADDR_PKT_DELAY   5'h11
`define ADDR_HDR_ADDR    5'h12
`define ADDR_HDR_EXT     5'h13
`define ADDR_RATE_LOW    5'h14
`define ADDR_IF_HIGH     5'h15
`define ADDR_IF_LOW      5'h16
`define ADDR_DEMOD_DIV   5'h17
`define ADDR_DEMOD_RATE  5'h18
`define ADDR_DEMOD_FILT  5'h19
`define ADDR_DEMOD_THR   5'h1a
`define ADDR_DEMOD_HOLD  5'h1b
`define ADDR_RSVD_HIGH   5'h1f
`define BANK_PTR_LSB     0
`define BANK_RESERVED    2'h3
`define POWER_ON_BIT     7
`define RESET_CLK_POR    8'h90
`define RESET_CLK_SOFT   8'h10
`define RESET_CLK_KEEP   8'h8e
`define IRQ_CFG_INIT     8'h09
`define BANK_INIT        8'h00
`define COMMON_INIT      8'h00
`define WMASK_RADIO_CFG  8'h73
`define WMASK_RESET_CLK  8'h9f
`define WMASK_IRQ_CFG    8'h0f
`define WMASK_TX_FIFO_SA 8'h3f
`define CMD_SOFT_RESET   8'h80
`define CMD_SET_BANK     6'h24
`endif

// [logic/bank_pkg.sv]
// types shared by the register file modules
package bank_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {ST_CMD, ST_WDATA, ST_RDATA, ST_IGNORE} link_state_t;
  typedef struct packed {
    logic [2:0]               sck_s;
    logic [1:0]               csn_s;
    logic [1:0]               mosi_s;
    link_state_t              state;
    logic [2:0]               cnt;
    byte_t                    rx;
    byte_t                    tx;
    logic [5:0]               addr;
    logic                     miso;
    logic                     oe_n;
    logic [31:0][7:0]         common;
  } main_state_t;
  typedef struct packed {
    logic [95:0][7:0]         mem;
  } store_state_t;
endpackage

// [logic/bank_if.sv]
// carrier between command logic and banked storage
`timescale 1ns/1ns
interface bank_if;
  logic       we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       soft_rst;
  modport ctrl  (output we, addr, wdata, soft_rst, input rdata);
  modport store (input we, addr, wdata, soft_rst, output rdata);
endinterface

// [logic/bank_storage.sv]
// three banked 32-byte register spaces
`timescale 1ns/1ns
`include "bank_map.svh"
module bank_storage (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // access from command logic
  bank_if.store    ifc
);
  bank_pkg::store_state_t s_reg;
  bank_pkg::store_state_t s_next;

  function automatic bank_pkg::store_state_t init_state();
    bank_pkg::store_state_t v;
    for (int i = 0; i < `BANK_DEPTH; i++) begin
      v.mem[i] = `BANK_INIT;
    end
    return v;
  endfunction

  localparam bank_pkg::store_state_t INIT = init_state();

  assign ifc.rdata = s_reg.mem[ifc.addr];

  always_comb begin
    s_next = s_reg;
    if (ifc.soft_rst) begin
      s_next = INIT;
    end else if (ifc.we) begin
      s_next.mem[ifc.addr] = ifc.wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= INIT;
    end else begin
      s_reg <= s_next;
    end
  end

  chk_bank_store: assert property (@(posedge clk) disable iff (!arst_n)
    ifc.we && !ifc.soft_rst |=>
      s_reg.mem[$past(ifc.addr)] == $past(ifc.wdata))
    else $error("bank write not stored");
  chk_bank_clear: assert property (@(posedge clk) disable iff (!arst_n)
    ifc.soft_rst |=> s_reg.mem[0] == `BANK_INIT)
    else $error("bank not cleared by soft reset");

endmodule // bank_storage

// [logic/banked_control_register_file.sv]
// banked control register file behind the serial command port
//
// Operation
// - 00h-1Fh always reach the common area
// - three 32-byte banks picked by pointer
// - set-bank strobe loads the pointer directly
// - pointer also read/written as common field
// - power-on reset loads all initial values
// - soft reset strobe restores initial values
// - soft reset keeps clock, flag, pad bits
// - frames: command plus data, or strobe alone
// - pointer 00/01/10 banks, 11 reserved
`timescale 1ns/1ns
`include "bank_map.svh"
module banked_control_register_file (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // serial command port
  input  wire logic       csn,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso_out,
  output logic            miso_oe_n,
  // control outputs
  output logic [1:0]      bank_select,
  output logic            power_on_flag
);
  bank_if ifc ();

  bank_storage u_store (
    .clk    (clk),
    .arst_n (arst_n),
    .ifc    (ifc.store)
  );

  bank_pkg::main_state_t s_reg;
  bank_pkg::main_state_t s_next;

  // reset value of a common byte
  function automatic bank_pkg::byte_t por_val(input logic [4:0] a);
    case (a)
      `ADDR_RESET_CLK: por_val = `RESET_CLK_POR;
      `ADDR_IRQ_CFG:   por_val = `IRQ_CFG_INIT;
      default:         por_val = `COMMON_INIT;
    endcase
  endfunction

  // value a soft reset drives into the non-kept bits
  function automatic bank_pkg::byte_t soft_val(input logic [4:0] a);
    case (a)
      `ADDR_RESET_CLK: soft_val = `RESET_CLK_SOFT;
      `ADDR_IRQ_CFG:   soft_val = `IRQ_CFG_INIT;
      default:         soft_val = `COMMON_INIT;
    endcase
  endfunction

  // bits that survive a soft reset
  function automatic bank_pkg::byte_t keep_mask(input logic [4:0] a);
    case (a)
      `ADDR_RESET_CLK:  keep_mask = `RESET_CLK_KEEP;
      `ADDR_GPIO_LOW:   keep_mask = 8'hff;
      `ADDR_GPIO_HIGH:  keep_mask = 8'hff;
      `ADDR_PAD_PULLUP: keep_mask = 8'hff;
      default:          keep_mask = 8'h00;
    endcase
  endfunction

  // bits the host may write; bits outside the masks of 00h, 01h, 02h and 09h are held
  function automatic bank_pkg::byte_t write_mask(input logic [4:0] a);
    case (a)
      `ADDR_RADIO_CFG:  write_mask = `WMASK_RADIO_CFG;
      `ADDR_RESET_CLK:  write_mask = `WMASK_RESET_CLK;
      `ADDR_IRQ_CFG:    write_mask = `WMASK_IRQ_CFG;
      `ADDR_TX_FIFO_SA: write_mask = `WMASK_TX_FIFO_SA;
      default:          write_mask = 8'hff;
    endcase
  endfunction

  function automatic bank_pkg::main_state_t init_state();
    bank_pkg::main_state_t v;
    v.sck_s  = 3'h0;
    v.csn_s  = 2'h3;
    v.mosi_s = 2'h0;
    v.state  = bank_pkg::ST_CMD;
    v.cnt    = 3'h0;
    v.rx     = 8'h00;
    v.tx     = 8'h00;
    v.addr   = 6'h00;
    v.miso   = 1'b0;
    v.oe_n   = 1'b1;
    for (int i = 0; i < `COMMON_SIZE; i++) begin
      v.common[i] = por_val(5'(i));
    end
    return v;
  endfunction

  localparam bank_pkg::main_state_t INIT = init_state();

  // decode of the current transfer, shared with the checks
  logic            sck_rise;
  logic            sck_fall;
  logic            byte_done;
  bank_pkg::byte_t byte_val;
  logic [1:0]      bank_req;
  logic [5:0]      tgt;
  logic            do_write;
  logic            do_soft;
  logic            do_set_bank;
  logic            bank_ok;
  bank_pkg::byte_t rd_val;
  logic [1:0]      bank_ptr;

  always_comb begin
    s_next      = s_reg;
    bank_ptr    = s_reg.common[`ADDR_RADIO_CFG][1:0];
    bank_ok     = bank_ptr != `BANK_RESERVED;
    s_next.sck_s  = {s_reg.sck_s[1:0], sck};
    s_next.csn_s  = {s_reg.csn_s[0], csn};
    s_next.mosi_s = {s_reg.mosi_s[0], mosi};
    sck_rise    = s_reg.sck_s[1] && !s_reg.sck_s[2];
    sck_fall    = !s_reg.sck_s[1] && s_reg.sck_s[2];
    byte_done   = 1'b0;
    byte_val    = {s_reg.rx[6:0], s_reg.mosi_s[1]};
    bank_req    = byte_val[1:0];
    do_write    = 1'b0;
    do_soft     = 1'b0;
    do_set_bank = 1'b0;
    case (s_reg.state)
      bank_pkg::ST_CMD:   tgt = byte_val[5:0];
      bank_pkg::ST_RDATA: tgt = s_reg.addr + 6'h01;
      default:            tgt = s_reg.addr;
    endcase
    ifc.addr     = {bank_ptr, tgt[4:0]};
    ifc.wdata    = byte_val;
    ifc.we       = 1'b0;
    ifc.soft_rst = 1'b0;
    if (!tgt[5]) begin
      rd_val = s_reg.common[tgt[4:0]];
    end else if (bank_ok) begin
      rd_val = ifc.rdata;
    end else begin
      rd_val = 8'h00;
    end

    if (s_reg.csn_s[1]) begin
      // frame ended: return to command byte
      s_next.state = bank_pkg::ST_CMD;
      s_next.cnt   = 3'h0;
      s_next.oe_n  = 1'b1;
      s_next.tx    = 8'h00;
    end else begin
      if (sck_fall) begin
        s_next.miso = s_reg.tx[7];
        s_next.tx   = {s_reg.tx[6:0], 1'b0};
      end
      if (sck_rise) begin
        s_next.rx  = byte_val;
        s_next.cnt = s_reg.cnt + 3'h1;
        byte_done  = s_reg.cnt == 3'h7;
      end
      if (byte_done) begin
        case (s_reg.state)
          bank_pkg::ST_CMD: begin
            if (byte_val[7]) begin
              // command-only strobes; trailing bytes ignored
              s_next.state = bank_pkg::ST_IGNORE;
              if (byte_val == `CMD_SOFT_RESET) begin
                do_soft = 1'b1;
              end else if (byte_val[7:2] == `CMD_SET_BANK) begin
                do_set_bank = 1'b1;
              end
            end else if (byte_val[6]) begin
              s_next.state = bank_pkg::ST_RDATA;
              s_next.addr  = tgt;
              s_next.tx    = rd_val;
              s_next.oe_n  = 1'b0;
            end else begin
              s_next.state = bank_pkg::ST_WDATA;
              s_next.addr  = tgt;
            end
          end
          bank_pkg::ST_WDATA: begin
            do_write    = 1'b1;
            s_next.addr = tgt + 6'h01;
          end
          bank_pkg::ST_RDATA: begin
            // address runs on for burst reads
            s_next.addr = tgt;
            s_next.tx   = rd_val;
          end
          bank_pkg::ST_IGNORE: begin
            s_next.state = bank_pkg::ST_IGNORE;
          end
          default: begin
            s_next.state = bank_pkg::ST_CMD;
          end
        endcase
      end
    end

    if (do_write) begin
      if (tgt[5]) begin
        ifc.we = bank_ok;
      end else begin
        s_next.common[tgt[4:0]] =
          (s_reg.common[tgt[4:0]] & ~write_mask(tgt[4:0])) |
          (byte_val & write_mask(tgt[4:0]));
      end
    end

    if (do_set_bank) begin
      s_next.common[`ADDR_RADIO_CFG][1:0] = bank_req;
    end

    if (do_soft) begin
      ifc.soft_rst = 1'b1;
      for (int i = 0; i < `COMMON_SIZE; i++) begin
        s_next.common[i] =
          (s_reg.common[i] & keep_mask(5'(i))) |
          (soft_val(5'(i)) & ~keep_mask(5'(i)));
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= INIT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign miso_out      = s_reg.miso;
  assign miso_oe_n     = s_reg.oe_n;
  assign bank_select   = s_reg.common[`ADDR_RADIO_CFG][1:0];
  assign power_on_flag = s_reg.common[`ADDR_RESET_CLK][`POWER_ON_BIT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence set_bank_seq;
    byte_done && s_reg.state == bank_pkg::ST_CMD &&
      byte_val[7:2] == `CMD_SET_BANK;
  endsequence

  sequence soft_seq;
    byte_done && s_reg.state == bank_pkg::ST_CMD &&
      byte_val == `CMD_SOFT_RESET;
  endsequence

  sequence ptr_write_seq;
    byte_done && s_reg.state == bank_pkg::ST_WDATA &&
      tgt == 6'h00;
  endsequence

  sequence common_read_seq;
    byte_done && s_reg.state == bank_pkg::ST_CMD &&
      byte_val[7:6] == 2'b01 && !tgt[5];
  endsequence

  sequence bank_read_seq;
    byte_done && s_reg.state == bank_pkg::ST_CMD &&
      byte_val[7:6] == 2'b01 && tgt[5] && bank_ok;
  endsequence

  sequence reserved_read_seq;
    byte_done && s_reg.state == bank_pkg::ST_CMD &&
      byte_val[7:6] == 2'b01 && tgt[5] && !bank_ok;
  endsequence

  sequence other_strobe_seq;
    byte_done && s_reg.state == bank_pkg::ST_CMD && byte_val[7] &&
      byte_val != `CMD_SOFT_RESET && byte_val[7:2] != `CMD_SET_BANK;
  endsequence

  chk_bank_strobe: assert property (
    set_bank_seq |=> bank_select == $past(bank_req))
    else $error("set-bank strobe did not load pointer");

  chk_bank_field_write: assert property (
    ptr_write_seq |=> bank_select == $past(bank_req))
    else $error("pointer write not taken");

  chk_soft_keep: assert property (
    soft_seq |=> s_reg.common[6] == $past(s_reg.common[6]) &&
      s_reg.common[`ADDR_GPIO_HIGH] == $past(s_reg.common[`ADDR_GPIO_HIGH]) &&
      s_reg.common[8] == $past(s_reg.common[8]) &&
      (s_reg.common[`ADDR_RESET_CLK] & `RESET_CLK_KEEP) ==
      ($past(s_reg.common[`ADDR_RESET_CLK]) & `RESET_CLK_KEEP) &&
      power_on_flag == $past(power_on_flag))
    else $error("kept bits changed by soft reset");

  chk_soft_restore: assert property (
    soft_seq |=> s_reg.common[0] == `COMMON_INIT &&
      s_reg.common[2] == `IRQ_CFG_INIT ##1 s_reg.state != bank_pkg::ST_WDATA)
    else $error("soft reset did not restore values");

  chk_common_route: assert property (
    do_write && !tgt[5] |-> !ifc.we)
    else $error("common write leaked to bank");

  chk_bank_route: assert property (
    do_write && tgt[5] && bank_ok |->
      ifc.we && ifc.addr == {bank_select, tgt[4:0]})
    else $error("bank write misrouted");

  chk_reserved_bank: assert property (
    bank_select == `BANK_RESERVED |-> !ifc.we)
    else $error("write into reserved bank");

  chk_frame_end: assert property (
    s_reg.csn_s[1] |=> s_reg.state == bank_pkg::ST_CMD && miso_oe_n)
    else $error("frame end not honoured");

  chk_por_values: assert property (
    $rose(arst_n) |-> power_on_flag && bank_select == 2'h0 &&
      miso_oe_n && s_reg.common[`ADDR_RESET_CLK] == `RESET_CLK_POR &&
      s_reg.common[`ADDR_IRQ_CFG] == `IRQ_CFG_INIT)
    else $error("power-on values not loaded");

  chk_common_read: assert property (
    common_read_seq |=> s_reg.tx == $past(s_reg.common[tgt[4:0]]) &&
      !miso_oe_n)
    else $error("common read not loaded");

  chk_bank_read: assert property (
    bank_read_seq |=> s_reg.tx == $past(ifc.rdata) && !miso_oe_n &&
      $past(ifc.addr) == {$past(bank_select), $past(byte_val[4:0])})
    else $error("bank read not loaded");

  chk_reserved_read: assert property (
    reserved_read_seq |=> s_reg.tx == 8'h00 && !miso_oe_n)
    else $error("reserved bank read not zero");

  chk_other_strobe: assert property (
    other_strobe_seq |=> s_reg.common == $past(s_reg.common) &&
      s_reg.state == bank_pkg::ST_IGNORE)
    else $error("unknown strobe changed registers");

  chk_strobe_tail: assert property (
    s_reg.state == bank_pkg::ST_IGNORE |-> !ifc.we && !ifc.soft_rst &&
      !do_write && !do_set_bank)
    else $error("byte after strobe acted on");

  chk_miso_stands: assert property (
    !sck_fall |=> miso_out == $past(miso_out))
    else $error("serial output moved off a falling edge");

  chk_drive_in_read: assert property (
    !miso_oe_n |-> s_reg.state == bank_pkg::ST_RDATA)
    else $error("serial output driven outside a read");

  chk_soft_clear: assert property (
    soft_seq |=> bank_select == 2'h0 &&
      (s_reg.common[`ADDR_RESET_CLK] & ~`RESET_CLK_KEEP) ==
      (`RESET_CLK_SOFT & ~`RESET_CLK_KEEP) &&
      s_reg.common[`ADDR_TX_PREAMB] == `COMMON_INIT)
    else $error("soft reset left a cleared field set");

endmodule // banked_control_register_file

// [sim/host_serial_model.sv]
// host side of the serial command port
`timescale 1ns/1ns
module host_serial_model (
  // clock
  input  wire logic clk,
  // serial command port
  output logic      csn,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso_out,
  input  wire logic miso_oe_n
);
  initial begin
    csn = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end

  // mode 0, msb first, sck high for 8 clk, low for 9 clk
  task automatic xfer(input bank_pkg::byte_t tx, output bank_pkg::byte_t rx);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk) mosi = tx[i];
      repeat (8) @(negedge clk);
      // released output reads as its pull-up level
      rx[i] = miso_oe_n ? 1'b1 : miso_out;
      sck = 1'b1;
      repeat (8) @(negedge clk);
      sck = 1'b0;
    end
  endtask

  // frame opens with select low, command byte comes first
  task automatic start();
    @(negedge clk) csn = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  // released data line shows the inverse of its last level
  task automatic stop();
    repeat (8) @(negedge clk);
    csn = 1'b1;
    mosi = ~mosi;
    repeat (8) @(negedge clk);
  endtask
endmodule // host_serial_model

// [sim/tb_top.sv]
// testbench for the banked control register file
`timescale 1ns/1ns
module tb_top;
  logic            clk;
  logic            arst_n;
  logic            csn;
  logic            sck;
  logic            mosi;
  logic            miso_out;
  logic            miso_oe_n;
  logic [1:0]      bank_select;
  logic            power_on_flag;
  int              err_total;
  int              comparisons;
  bank_pkg::byte_t junk;

  always #2 clk = ~clk;

  banked_control_register_file banked_control_register_file_inst (
    .clk(clk), .arst_n(arst_n), .csn(csn), .sck(sck), .mosi(mosi),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .bank_select(bank_select), .power_on_flag(power_on_flag));

  host_serial_model host_serial_model_inst (
    .clk(clk), .csn(csn), .sck(sck), .mosi(mosi),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n));

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic x(input bank_pkg::byte_t t);
    host_serial_model_inst.xfer(t, junk);
  endtask

  task automatic wr(input logic [5:0] a, input bank_pkg::byte_t d);
    host_serial_model_inst.start();
    x({2'b00, a});
    x(d);
    host_serial_model_inst.stop();
  endtask

  task automatic rd(input logic [5:0] a, input bank_pkg::byte_t e);
    bank_pkg::byte_t d;
    host_serial_model_inst.start();
    x({2'b01, a});
    host_serial_model_inst.xfer(8'h00, d);
    check("drive enable in read", {7'h00, miso_oe_n}, 8'h00);
    host_serial_model_inst.stop();
    check($sformatf("byte %h", a), d, e);
    check("drive enable idle", {7'h00, miso_oe_n}, 8'h01);
  endtask

  task automatic strobe(input bank_pkg::byte_t c);
    host_serial_model_inst.start();
    x(c);
    host_serial_model_inst.stop();
  endtask

  // reserved place 1fh is only ever read; 05h is never accessed
  task automatic por_checks();
    check("pointer", {6'h00, bank_select}, 8'h00);
    check("power flag", {7'h00, power_on_flag}, 8'h01);
    rd(6'h00, 8'h00);
    rd(6'h01, 8'h90);
    rd(6'h02, 8'h09);
    rd(6'h06, 8'h00);
    rd(6'h1f, 8'h00);
    rd(6'h20, 8'h00);
    rd(6'h3f, 8'h00);
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    err_total = 0;
    comparisons = 0;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    repeat (8) @(negedge clk);
    por_checks();
    // read-only bits refused, pointer through plain writes
    wr(6'h02, 8'hff);
    rd(6'h02, 8'h0f);
    wr(6'h00, 8'hff);
    check("pointer", {6'h00, bank_select}, 8'h03);
    rd(6'h00, 8'h73);
    wr(6'h20, 8'h5a);
    rd(6'h20, 8'h00);
    wr(6'h00, 8'h01);
    check("pointer", {6'h00, bank_select}, 8'h01);
    for (int b = 0; b < 3; b++) begin
      strobe(8'h90 | 8'(b));
      check("pointer", {6'h00, bank_select}, 8'(b));
      wr(6'h20, 8'ha0 + 8'(b));
      wr(6'h3f, 8'hb0 + 8'(b));
    end
    for (int b = 0; b < 3; b++) begin
      strobe(8'h90 | 8'(b));
      rd(6'h20, 8'ha0 + 8'(b));
      rd(6'h3f, 8'hb0 + 8'(b));
    end
    wr(6'h10, 8'h5a);
    strobe(8'h90);
    rd(6'h10, 8'h5a);
    // burst write, then strobe with a stray byte behind it
    host_serial_model_inst.start();
    x(8'h0f);
    x(8'h11);
    x(8'h22);
    host_serial_model_inst.stop();
    rd(6'h0f, 8'h11);
    rd(6'h10, 8'h22);
    // burst read runs the address on
    host_serial_model_inst.start();
    x(8'h4f);
    host_serial_model_inst.xfer(8'h00, junk);
    check("burst first", junk, 8'h11);
    host_serial_model_inst.xfer(8'h00, junk);
    check("burst second", junk, 8'h22);
    host_serial_model_inst.stop();
    host_serial_model_inst.start();
    x(8'h91);
    x(8'h00);
    host_serial_model_inst.stop();
    check("pointer", {6'h00, bank_select}, 8'h01);
    rd(6'h00, 8'h01);
    // unknown strobe has no effect
    strobe(8'hc5);
    check("pointer", {6'h00, bank_select}, 8'h01);
    rd(6'h0f, 8'h11);
    // soft reset keeps clock, flag and pad bits
    wr(6'h01, 8'h0f);
    check("power flag", {7'h00, power_on_flag}, 8'h00);
    wr(6'h06, 8'ha5);
    wr(6'h07, 8'h5a);
    wr(6'h08, 8'hc3);
    wr(6'h0b, 8'h77);
    strobe(8'h80);
    check("power flag", {7'h00, power_on_flag}, 8'h00);
    check("pointer", {6'h00, bank_select}, 8'h00);
    rd(6'h01, 8'h1e);
    rd(6'h02, 8'h09);
    rd(6'h06, 8'ha5);
    rd(6'h07, 8'h5a);
    rd(6'h08, 8'hc3);
    rd(6'h0b, 8'h00);
    rd(6'h20, 8'h00);
    // power-on reset in mid-run
    wr(6'h20, 8'hc3);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (8) @(negedge clk);
    por_checks();
    print_verdict();
  end
endmodule // tb_top
